// ### hdl/srd_sar_readout.sv
// Serial readout and power-mode control for the successive-approximation converter
`timescale 1ns/1ps

module srd_sar_readout import srd_pkg::*; #(
    parameter int RES_BITS = RES_BITS_12
) (
    // Clock, reset, enable
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    // Serial pins from the host
    input wire logic cs_n_in,
    input wire logic sclk_in,
    // Serial data pin, two signals
    output logic serial_result_out,
    output logic serial_result_oe_out,
    // Converter core
    input wire logic [RES_BITS-1:0] result_in,
    output logic sample_out,
    // Status toward the analog section
    output srd_status_t status_out
);

    // Pin synchronisers
    logic cs_meta_q;
    logic cs_sync_q;
    logic cs_prev_q;
    logic sclk_meta_q;
    logic sclk_sync_q;
    logic sclk_prev_q;

    // Frame and power state
    srd_frame_t fr_q;
    srd_power_t pw_q;
    logic [CNT_W-1:0] cnt_q;
    logic [UP_W-1:0] up_cnt_q;
    logic hold_q;
    logic sdo_q;
    logic oe_q;
    logic sample_q;
    logic frame_valid_q;

    // Events, gated so a frozen clock enable never repeats one
    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;
    logic sclk_rise;
    logic shifting;
    logic going_down;
    logic fully_up;
    logic [FRAME_BITS-1:0] frame_w;
    logic [3:0] bit_idx;

    // Places the result below the leading zeros; ten-bit gets trailing zeros
    function automatic logic [FRAME_BITS-1:0] frame_word(input logic [RES_BITS-1:0] r);
        logic [FRAME_BITS-1:0] w;
        w = '0;
        w[FRAME_BITS-LEAD_ZEROS-1 -: RES_BITS] = r;
        return w;
    endfunction

    // Two stages before anything looks at the pins
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cs_meta_q <= PIN_CS_RESET;
            cs_sync_q <= PIN_CS_RESET;
            cs_prev_q <= PIN_CS_RESET;
        end else if (ce_in) begin
            cs_meta_q <= cs_n_in;
            cs_sync_q <= cs_meta_q;
            cs_prev_q <= cs_sync_q;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            sclk_meta_q <= PIN_SCLK_RESET;
            sclk_sync_q <= PIN_SCLK_RESET;
            sclk_prev_q <= PIN_SCLK_RESET;
        end else if (ce_in) begin
            sclk_meta_q <= sclk_in;
            sclk_sync_q <= sclk_meta_q;
            sclk_prev_q <= sclk_sync_q;
        end
    end

    assign cs_fall = ce_in && cs_prev_q && !cs_sync_q;
    assign cs_rise = ce_in && !cs_prev_q && cs_sync_q;
    // Serial clock edges only count while chip select is low
    assign sclk_fall = ce_in && !cs_sync_q && sclk_prev_q && !sclk_sync_q;
    assign sclk_rise = ce_in && !cs_sync_q && !sclk_prev_q && sclk_sync_q;
    assign shifting = (fr_q == FR_SHIFT);
    assign frame_w = frame_word(result_in);
    assign bit_idx = FIRST_SHIFT_IDX - cnt_q[3:0];

    // Early rise decides power-down; glitches before second fall ignored in normal mode
    assign going_down = shifting && (cnt_q < EDGE_STAY_UP)
                        && ((pw_q == PW_WAKE) || (cnt_q >= EDGE_PD_MIN));

    assign fully_up = (pw_q != PW_DOWN) && (up_cnt_q == UP_W'(POWER_UP_CYC));

    // Frame sequencing and falling edge count
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            fr_q <= FR_IDLE;
            cnt_q <= CNT_RESET;
        end else if (ce_in) begin
            if (cs_fall) begin
                fr_q <= FR_SHIFT;
                cnt_q <= CNT_RESET;
            end else if (cs_rise) begin
                fr_q <= FR_IDLE;
            end else if (sclk_fall && shifting) begin
                cnt_q <= cnt_q + 5'h01;
                if (cnt_q == EDGE_LAST_SHIFT) begin
                    fr_q <= FR_DONE;
                end
            end
        end
    end

    // Serial data pin; bits move on falling edges only
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            oe_q <= 1'b0;
            sdo_q <= 1'b0;
        end else if (ce_in) begin
            if (cs_fall) begin
                oe_q <= 1'b1;
                sdo_q <= frame_w[FRAME_BITS-1];
            end else if (cs_rise) begin
                oe_q <= 1'b0;
                sdo_q <= 1'b0;
            end else if (sclk_fall && shifting) begin
                if (cnt_q == EDGE_LAST_SHIFT) begin
                    oe_q <= 1'b0;
                    sdo_q <= 1'b0;
                end else begin
                    sdo_q <= frame_w[bit_idx];
                end
            end
        end
    end

    // Track-and-hold control
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            hold_q <= 1'b0;
        end else if (ce_in) begin
            if (cs_fall) begin
                hold_q <= 1'b1;
            end else if (cs_rise) begin
                // Powered-down part keeps its hold until woken
                hold_q <= going_down || (pw_q == PW_DOWN);
            end else if ((pw_q == PW_WAKE) && (sclk_rise || sclk_fall)) begin
                hold_q <= 1'b0;
            end else if (sclk_rise && shifting && (cnt_q >= EDGE_TRACK)) begin
                hold_q <= 1'b0;
            end
        end
    end

    // One-cycle sample strobe to the converter core
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            sample_q <= 1'b0;
        end else if (ce_in) begin
            sample_q <= cs_fall;
        end
    end

    // Power mode; chip select rise wins over a coincident clock edge
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            pw_q <= PW_NORMAL;
        end else if (ce_in) begin
            if (cs_fall && (pw_q == PW_DOWN)) begin
                pw_q <= PW_WAKE;
            end else if (cs_rise) begin
                if (going_down) begin
                    pw_q <= PW_DOWN;
                end
            end else if (sclk_fall && (pw_q == PW_WAKE) && (cnt_q == EDGE_STAY_UP - 5'h01)) begin
                pw_q <= PW_NORMAL;
            end
        end
    end

    // Power-up timer from the waking chip select fall
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            up_cnt_q <= UP_W'(POWER_UP_CYC);
        end else if (ce_in) begin
            if ((pw_q == PW_DOWN) || (cs_rise && going_down)) begin
                up_cnt_q <= '0;
            end else if (up_cnt_q != UP_W'(POWER_UP_CYC)) begin
                up_cnt_q <= up_cnt_q + UP_W'(1);
            end
        end
    end

    // Frame yields valid data only if the part was fully up when it began
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            frame_valid_q <= 1'b0;
        end else if (ce_in) begin
            if (cs_fall) begin
                frame_valid_q <= fully_up;
            end
        end
    end

    assign serial_result_out = sdo_q;
    assign serial_result_oe_out = oe_q;
    assign sample_out = sample_q;
    assign status_out.hold = hold_q;
    assign status_out.converting = (fr_q == FR_SHIFT);
    assign status_out.analog_off = (pw_q == PW_DOWN);
    assign status_out.fully_up = fully_up;
    assign status_out.frame_valid = frame_valid_q;

    property p_cs_fall_drive;
        @(posedge clk_in) disable iff (reset_in)
        cs_fall |=> oe_q && hold_q && !sdo_q && sample_q && (cnt_q == CNT_RESET);
    endproperty
    a_cs_fall_drive: assert property (p_cs_fall_drive) else $error("frame start not driven");

    property p_release_16;
        @(posedge clk_in) disable iff (reset_in)
        sclk_fall && shifting && !cs_rise && (cnt_q == EDGE_LAST_SHIFT)
        |=> !oe_q && (fr_q == FR_DONE);
    endproperty
    a_release_16: assert property (p_release_16) else $error("output not released on 16th fall");

    property p_abort;
        @(posedge clk_in) disable iff (reset_in)
        cs_rise && shifting |=> !oe_q && (fr_q == FR_IDLE);
    endproperty
    a_abort: assert property (p_abort) else $error("early rise did not abandon frame");

    property p_track_13;
        @(posedge clk_in) disable iff (reset_in)
        sclk_rise && shifting && (cnt_q == EDGE_TRACK) |=> !hold_q;
    endproperty
    a_track_13: assert property (p_track_13) else $error("no return to track after 13th fall");

    property p_hold_before_13;
        @(posedge clk_in) disable iff (reset_in)
        shifting && hold_q && (pw_q == PW_NORMAL) && (cnt_q < EDGE_TRACK) && !cs_rise |=> hold_q;
    endproperty
    a_hold_before_13: assert property (p_hold_before_13) else $error("track resumed too early");

    property p_shift_fall_only;
        @(posedge clk_in) disable iff (reset_in)
        oe_q && !sclk_fall && !cs_fall && !cs_rise |=> $stable(sdo_q);
    endproperty
    a_shift_fall_only: assert property (p_shift_fall_only) else $error("data moved off a fall");

    property p_lead_zeros;
        @(posedge clk_in) disable iff (reset_in)
        sclk_fall && shifting && !cs_rise && (cnt_q < 5'h03) |=> !sdo_q;
    endproperty
    a_lead_zeros: assert property (p_lead_zeros) else $error("leading zero missing");

    property p_power_down;
        @(posedge clk_in) disable iff (reset_in)
        cs_rise && shifting && (pw_q == PW_NORMAL) && (cnt_q >= EDGE_PD_MIN)
        && (cnt_q < EDGE_STAY_UP) |=> (pw_q == PW_DOWN) && status_out.analog_off;
    endproperty
    a_power_down: assert property (p_power_down) else $error("power-down window missed");

    property p_glitch_reject;
        @(posedge clk_in) disable iff (reset_in)
        cs_rise && (pw_q == PW_NORMAL) && (cnt_q < EDGE_PD_MIN) |=> (pw_q == PW_NORMAL);
    endproperty
    a_glitch_reject: assert property (p_glitch_reject) else $error("glitch caused power-down");

    property p_stay_up;
        @(posedge clk_in) disable iff (reset_in)
        cs_rise && (pw_q == PW_NORMAL) && (cnt_q >= EDGE_STAY_UP) |=> (pw_q == PW_NORMAL) && !oe_q;
    endproperty
    a_stay_up: assert property (p_stay_up) else $error("late rise changed power mode");

    property p_wake_back;
        @(posedge clk_in) disable iff (reset_in)
        cs_rise && (pw_q == PW_WAKE) |=> (pw_q == PW_DOWN) && hold_q;
    endproperty
    a_wake_back: assert property (p_wake_back) else $error("aborted wake did not power down");

    property p_wake_track;
        @(posedge clk_in) disable iff (reset_in)
        (pw_q == PW_WAKE) && sclk_rise && !cs_rise && !cs_fall |=> !hold_q;
    endproperty
    a_wake_track: assert property (p_wake_track) else $error("wake did not return to track");

endmodule

// ### inc/srd_pkg.sv
// Constants and types for the converter serial readout and power-mode control
// How it works
// - Chip select fall holds input, samples, starts conversion, drives data out.
// - Full conversion and readout take sixteen serial clocks after chip select falls.
// - After thirteenth clock fall, track resumes on the next clock rise.
// - Data output returns to high impedance on the sixteenth clock fall.
// - Chip select rising early abandons conversion and releases the data output.
// - Result bits change on serial clock falling edges only.
// - Twelve-bit frame: four zeros then twelve result bits, MSB first.
// - Ten-bit frame: four zeros, ten result bits MSB first, two zeros.
// - Result is plain unsigned binary, passed through unchanged.
// - First zero at chip select fall; final bit shifted on fifteenth fall.
// - Chip select held through ten clock falls keeps normal mode powered.
// - Rise between tenth and sixteenth fall: stay up, abandon, release output.
// - Rise after second, before tenth fall: power down, abandon, release output.
// - Rise before second fall keeps normal mode, rejecting glitches.
// - Dummy conversion past tenth fall wakes part; fully up after 1 us.
// - While waking, rise before tenth fall returns the part to power-down.
// - When waking, first serial clock edge after chip select fall returns to track.
package srd_pkg;

    // Frame layout
    localparam int FRAME_BITS = 16;
    localparam int LEAD_ZEROS = 4;
    localparam int RES_BITS_12 = 12;
    localparam int RES_BITS_10 = 10;
    localparam int CNT_W = 5;

    // Falling edge counts that steer decisions
    localparam logic [CNT_W-1:0] EDGE_FRAME = 5'h10;
    localparam logic [CNT_W-1:0] EDGE_LAST_SHIFT = 5'h0f;
    localparam logic [CNT_W-1:0] EDGE_TRACK = 5'h0d;
    localparam logic [CNT_W-1:0] EDGE_PD_MIN = 5'h02;
    localparam logic [CNT_W-1:0] EDGE_STAY_UP = 5'h0a;
    localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;
    localparam logic [3:0] FIRST_SHIFT_IDX = 4'he;

    // Timing, clock period in ns
    localparam int CLK_PERIOD_NS = 100;
    localparam int POWER_UP_NS = 1000;
    localparam int POWER_UP_CYC = (POWER_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int UP_W = $clog2(POWER_UP_CYC + 1);
    localparam int ACQUISITION_INTERVAL_NS = 290;
    localparam int BUS_QUIET_INTERVAL_NS = 60;
    localparam int OUTPUT_RELEASE_DELAY_NS = 35;

    // Pin synchroniser value after reset, chip select deselected
    localparam logic PIN_CS_RESET = 1'b1;
    localparam logic PIN_SCLK_RESET = 1'b0;

    typedef enum logic [2:0] {
        FR_IDLE = 3'b001,
        FR_SHIFT = 3'b010,
        FR_DONE = 3'b100
    } srd_frame_t;

    typedef enum logic [2:0] {
        PW_NORMAL = 3'b001,
        PW_DOWN = 3'b010,
        PW_WAKE = 3'b100
    } srd_power_t;

    typedef struct packed {
        logic hold;
        logic converting;
        logic analog_off;
        logic fully_up;
        logic frame_valid;
    } srd_status_t;

endpackage

// ### tb/srd_host_model.sv
// Host serial controller model driving chip select and serial clock
`timescale 1ns/1ps

module srd_host_model (
    // Clock
    input wire logic clk_in,
    // Data wire from the device
    input wire logic data_in,
    input wire logic data_oe_in,
    // Host pins
    output logic cs_n_out,
    output logic sclk_out
);
    // Half serial period in clk_in cycles, slow enough for the synchronisers
    localparam int HALF = 6;
    logic [15:0] word;
    logic [4:0] falls;
    logic oe_pre;
    logic oe_rel;
    logic last_q;
    logic rd;

    // Released wire floats; show the inverse of the last driven bit
    assign rd = data_oe_in ? data_in : ~last_q;

    always @(posedge clk_in) if (data_oe_in) last_q <= data_in;

    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        last_q = 1'b0;
        word = 16'h0000;
        falls = 5'h00;
        oe_pre = 1'b0;
        oe_rel = 1'b0;
    end

    // One frame of n falling edges; bit k taken at rise k+1, ahead of fall k+1
    task automatic frame(input int n);
        word = 16'h0000;
        @(negedge clk_in);
        falls = 5'h00;
        cs_n_out = 1'b0;
        repeat (HALF) @(negedge clk_in);
        for (int i = 1; i <= n; i++) begin
            if (i <= 16) word[16-i] = rd;
            sclk_out = 1'b1;
            repeat (HALF) @(negedge clk_in);
            sclk_out = 1'b0;
            falls = 5'(i);
            repeat (HALF) @(negedge clk_in);
        end
        oe_pre = data_oe_in;
        cs_n_out = 1'b1;
        // Quiet and acquisition time kept well above the minimum
        repeat (12) @(negedge clk_in);
        oe_rel = data_oe_in;
    endtask
endmodule

// ### tb/sar_adc_serial_readout_power_modes_bench.sv
// Self-checking bench for the converter serial readout and power modes
`timescale 1ns/1ps

module sar_adc_serial_readout_power_modes_bench import srd_pkg::*;;
    logic clk_in;
    logic reset_in;
    logic ce;
    logic cs_n;
    logic sclk;
    logic d12;
    logic oe12;
    logic smp12;
    logic d10;
    logic oe10;
    logic use10;
    logic [11:0] res12;
    logic [9:0] res10;
    srd_status_t st12;
    srd_status_t st10;
    logic [31:0] hold_at;
    int n_errors;
    int n_checks;
    int n_samp;

    srd_sar_readout #(.RES_BITS(12)) DUT (.clk_in(clk_in), .reset_in(reset_in),
        .ce_in(ce), .cs_n_in(cs_n), .sclk_in(sclk), .serial_result_out(d12),
        .serial_result_oe_out(oe12), .result_in(res12), .sample_out(smp12),
        .status_out(st12));
    srd_sar_readout #(.RES_BITS(10)) DUT_10 (.clk_in(clk_in), .reset_in(reset_in),
        .ce_in(ce), .cs_n_in(cs_n), .sclk_in(sclk), .serial_result_out(d10),
        .serial_result_oe_out(oe10), .result_in(res10), .sample_out(),
        .status_out(st10));
    srd_host_model host (.clk_in(clk_in), .data_in(use10 ? d10 : d12),
        .data_oe_in(use10 ? oe10 : oe12), .cs_n_out(cs_n), .sclk_out(sclk));

    always #50 clk_in = ~clk_in;
    // Counted on the falling edge, half a cycle after the launching rise, so the one-cycle strobe is settled
    always @(negedge clk_in) if (smp12) n_samp++;
    // Track-and-hold state last seen at each fall count
    always @(negedge clk_in) hold_at[host.falls] <= st12.hold;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic t_frame();
        for (int w = 0; w < 2; w++) begin
            for (int v = 0; v < 2; v++) begin
                use10 = w[0];
                res12 = v[0] ? 12'ha5c : 12'hfff;
                res10 = v[0] ? 10'h2a7 : 10'h3ff;
                n_samp = 0;
                host.frame(18);
                check(host.word, w[0] ? {4'h0, res10, 2'b00} : {4'h0, res12});
                check(16'(n_samp), 16'h0001);
                check(hold_at[12], 1'b1);
                check(hold_at[14], 1'b0);
                check(host.oe_pre, 1'b0);
                check({st10.converting, oe10}, 2'b00);
            end
        end
        use10 = 1'b0;
        $display("test frame done");
    endtask

    task automatic t_abort();
        host.frame(12);
        check(host.oe_pre, 1'b1);
        check(host.oe_rel, 1'b0);
        check(st12.analog_off, 1'b0);
        check(st12.hold, 1'b0);
        check(st12.converting, 1'b0);
        $display("test abort done");
    endtask

    // Frame that would power down, sent with the clock enable low
    task automatic t_freeze();
        n_samp = 0;
        ce = 1'b0;
        host.frame(2);
        check(host.oe_pre, 1'b0);
        check(st12.analog_off, 1'b0);
        check(16'(n_samp), 16'h0000);
        ce = 1'b1;
        repeat (4) @(negedge clk_in);
        check(st12.analog_off, 1'b0);
        check({oe12, st12.hold}, 2'b00);
        $display("test freeze done");
    endtask

    task automatic t_glitch();
        int ns[3] = '{0, 1, 10};
        foreach (ns[i]) begin
            host.frame(ns[i]);
            check(st12.analog_off, 1'b0);
            check(st12.fully_up, 1'b1);
            check(host.oe_rel, 1'b0);
        end
        $display("test glitch done");
    endtask

    task automatic t_power();
        // Rise right after the second fall is the lower edge of the window
        host.frame(2);
        check(st12.analog_off, 1'b1);
        check(st12.hold, 1'b1);
        check(st12.fully_up, 1'b0);
        check(host.oe_rel, 1'b0);
        host.frame(9);
        check(st12.analog_off, 1'b1);
        check(st12.hold, 1'b1);
        host.frame(16);
        check(hold_at[1], 1'b0);
        check(st12.analog_off, 1'b0);
        check(st12.fully_up, 1'b1);
        check(st12.frame_valid, 1'b0);
        host.frame(16);
        check(st12.frame_valid, 1'b1);
        check(host.word, {4'h0, res12});
        $display("test power done");
    endtask

    initial begin
        clk_in = 1'b0;
        reset_in = 1'b1;
        ce = 1'b1;
        use10 = 1'b0;
        res12 = 12'h000;
        res10 = 10'h000;
        hold_at = 32'h0000_0000;
        n_errors = 0;
        n_checks = 0;
        n_samp = 0;
        repeat (2) @(negedge clk_in);
        reset_in = 1'b0;
        check({oe12, d12, smp12, st12}, 16'h0002);
        t_frame();
        t_abort();
        t_glitch();
        t_freeze();
        t_power();
        end_of_test();
    end

    // Hang guard
    initial begin
        repeat (50000) @(posedge clk_in);
        n_errors++;
        end_of_test();
    end
endmodule
